// file: verilog/flash_cmd_pkg.sv
`default_nettype none
package flash_cmd_pkg;

    // ****************************************
    // instruction codes
    // ****************************************
    localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
    localparam logic [7:0] OP_RELEASE_ID = 8'hAB;
    localparam logic [7:0] OP_MAKER_DEV_ID = 8'h90;
    localparam logic [7:0] OP_MAKER_DEV_ID_DUAL = 8'h92;
    localparam logic [7:0] OP_UNIQUE_ID = 8'h4B;
    localparam logic [7:0] OP_STD_ID = 8'h9F;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;

    // ****************************************
    // frame lengths in bits
    // ****************************************
    localparam logic [5:0] CMD_BITS = 6'h08;
    localparam logic [5:0] ADDR_BITS = 6'h18;
    localparam logic [5:0] ADDR_MODE_BITS = 6'h20;
    localparam logic [5:0] UID_DUMMY_BITS = 6'h20;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [2:0] STD_ID_LAST = 3'h2;

    // ****************************************
    // identity values, all arbitrary
    // ****************************************
    localparam logic [7:0] MAKER_ID = 8'h5A;
    localparam logic [7:0] DEVICE_ID = 8'h12;
    localparam logic [7:0] MEMORY_TYPE_BYTE = 8'h30;
    localparam logic [7:0] CAPACITY_BYTE = 8'h13;
    localparam logic [63:0] UNIQUE_SERIAL = 64'h0123_4567_89AB_CDEF;

    // ****************************************
    // array layout and protection
    // ****************************************
    localparam int BLOCK_LSB = 16;
    localparam logic [3:0] NUM_BLOCKS = 4'h8;
    localparam logic [2:0] BP_ALL = 3'h4;
    localparam logic [15:0] BLOCK_OFFSET_ZERO = 16'h0000;
    localparam logic [3:0] PIN_RST = 4'h8;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int BLOCK_ERASE_CYCLE_TIME_US = 1000;
    localparam int ARRAY_ERASE_CYCLE_TIME_US = 10000;
    localparam int SLEEP_ENTRY_DELAY_NS = 3000;
    localparam int WAKE_DELAY_PLAIN_NS = 3000;
    localparam int WAKE_DELAY_WITH_IDENTIFIER_NS = 5000;
    localparam int BLOCK_ERASE_CYCLES = BLOCK_ERASE_CYCLE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int ARRAY_ERASE_CYCLES = ARRAY_ERASE_CYCLE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam logic [15:0] SLEEP_ENTRY_CYCLES = 16'(SLEEP_ENTRY_DELAY_NS / CLK_PERIOD_NS);
    localparam logic [15:0] WAKE_PLAIN_CYCLES = 16'(WAKE_DELAY_PLAIN_NS / CLK_PERIOD_NS);
    localparam logic [15:0] WAKE_ID_CYCLES = 16'(WAKE_DELAY_WITH_IDENTIFIER_NS / CLK_PERIOD_NS);

    // ****************************************
    // states
    // ****************************************
    typedef enum logic [2:0] {
        PH_CMD = 3'h0,
        PH_ADDR = 3'h1,
        PH_END = 3'h2,
        PH_OUT = 3'h3,
        PH_SKIP = 3'h4
    } phase_e;

    typedef enum logic [1:0] {
        PWR_NORMAL = 2'h0,
        PWR_ENTER = 2'h1,
        PWR_SLEEP = 2'h2,
        PWR_WAKE = 2'h3
    } pwr_e;

endpackage
`default_nettype wire

// file: verilog/spi_pin_if.sv
`timescale 1ns/10ps
`default_nettype none
interface spi_pin_if;
    logic cs_n;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic io0;
    logic io1;
    modport sync_mp(output cs_n, cs_rise, sclk_rise, sclk_fall, io0, io1);
    modport core_mp(input cs_n, cs_rise, sclk_rise, sclk_fall, io0, io1);
endinterface
`default_nettype wire

// file: verilog/spi_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module spi_pin_sync
    import flash_cmd_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // raw pins
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic io1_i,
    input wire logic io0_i,
    // filtered levels and edges
    spi_pin_if.sync_mp pins
);

    logic [3:0] raw;
    logic [3:0] s1_reg, s2_reg, s3_reg, lvl_reg;
    logic [3:0] lvl_next;

    assign raw = {cs_n_i, sclk_i, io1_i, io0_i};

    // ****************************************
    // three-stage capture, per pin
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_pin
            // a level moves only when the last two stages agree
            always_comb begin
                lvl_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : lvl_reg[g];
            end
            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    s1_reg[g] <= PIN_RST[g];
                    s2_reg[g] <= PIN_RST[g];
                    s3_reg[g] <= PIN_RST[g];
                    lvl_reg[g] <= PIN_RST[g];
                end else begin
                    s1_reg[g] <= raw[g];
                    s2_reg[g] <= s1_reg[g];
                    s3_reg[g] <= s2_reg[g];
                    lvl_reg[g] <= lvl_next[g];
                end
            end
        end
    endgenerate

    assign pins.cs_n = lvl_reg[3];
    assign pins.cs_rise = lvl_next[3] & ~lvl_reg[3];
    assign pins.sclk_rise = lvl_next[2] & ~lvl_reg[2];
    assign pins.sclk_fall = ~lvl_next[2] & lvl_reg[2];
    assign pins.io1 = lvl_reg[1];
    assign pins.io0 = lvl_reg[0];

endmodule
`default_nettype wire

// file: verilog/flash_cmd_core.sv
// Overview of operation
// - D8h plus 24-bit address erases the whole 64KB block holding it.
// - Erase instructions run only when the write enable latch is set.
// - Erase runs only if select rises right after the last byte's eighth bit.
// - Erase is self-timed with busy set; status reads still answered; busy clears.
// - Finishing a block or chip erase clears the write enable latch.
// - Block erase refused when its block is protected by the protect bits.
// - C7h or 60h alone, select raised after bit eight, erases the array.
// - Whole-array erase refused when any block is protected.
// - B9h alone enters the low-power state after the entry delay.
// - In low power only ABh is recognised; everything else is ignored.
// - The device starts in normal operation after reset.
// - ABh followed by select rising wakes the device after the plain delay.
// - ABh plus three dummy bytes streams the device identifier until select rises.
// - ABh arriving while busy is ignored and the cycle continues.
// - 90h with address 0 gives maker then device byte; address 1 swaps.
// - 92h takes address and mode field two bits per clock, answers likewise.
// - 4Bh plus four dummy bytes streams the 64-bit unique serial number.
// - 9Fh streams maker, memory type and capacity bytes, MSB first.
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_core
    import flash_cmd_pkg::*;
#(
    parameter int BLOCK_ERASE_CYC = BLOCK_ERASE_CYCLES,
    parameter int ARRAY_ERASE_CYC = ARRAY_ERASE_CYCLES
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // serial pins
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic io0_i,
    input wire logic io1_i,
    output logic io0_o,
    output logic io0_oe_o,
    output logic io1_o,
    output logic io1_oe_o,
    // protection and latch control
    input wire logic wel_set_i,
    input wire logic protect_top_bottom_select_i,
    input wire logic [2:0] block_protect_i,
    // status
    output logic write_enable_latch_o,
    output logic busy_o,
    output logic deep_sleep_o,
    // erase request to the array
    output logic erase_start_o,
    output logic erase_all_o,
    output logic [23:0] erase_addr_o
);

    spi_pin_if pins();

    spi_pin_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .cs_n_i(cs_n_i),
        .sclk_i(sclk_i),
        .io1_i(io1_i),
        .io0_i(io0_i),
        .pins(pins.sync_mp)
    );

    // ****************************************
    // state
    // ****************************************
    phase_e phase_reg, phase_next;
    pwr_e pwr_reg, pwr_next;
    logic [7:0] op_reg, op_next;
    logic [31:0] rx_reg, rx_next;
    logic [5:0] cnt_reg, cnt_next;
    logic [7:0] tx_reg, tx_next;
    logic [3:0] txcnt_reg, txcnt_next;
    logic [2:0] byte_reg, byte_next;
    logic dual_reg, dual_next;
    logic swap_reg, swap_next;
    logic [1:0] dout_reg, dout_next;
    logic oe_reg, oe_next;
    logic busy_reg, busy_next;
    logic wel_reg, wel_next;
    logic [31:0] ers_cnt_reg, ers_cnt_next;
    logic start_reg, start_next;
    logic all_reg, all_next;
    logic [23:0] eaddr_reg, eaddr_next;
    logic [15:0] pwr_cnt_reg, pwr_cnt_next;

    logic exec_block, exec_chip, exec_sleep, exec_wake_plain, exec_wake_id;
    logic [7:0] stat_byte;
    logic [7:0] in_byte;
    logic [31:0] rx_shift;
    logic [5:0] cnt_inc;
    logic [3:0] wstep;
    logic [2:0] byte_inc;

    // status byte: tb, bp2..0, latch, busy from bit 5 down to bit 0
    assign stat_byte = {2'h0, protect_top_bottom_select_i, block_protect_i, wel_reg, busy_reg};

    function automatic logic [7:0] id_byte(input logic [7:0] op, input logic [2:0] idx,
                                           input logic swap, input logic [7:0] stat);
        logic [63:0] uid;
        uid = UNIQUE_SERIAL >> {3'h7 - idx, 3'h0};
        case (op)
            OP_READ_STATUS: id_byte = stat;
            OP_RELEASE_ID: id_byte = DEVICE_ID;
            OP_MAKER_DEV_ID, OP_MAKER_DEV_ID_DUAL: id_byte = (idx[0] ^ swap) ? DEVICE_ID : MAKER_ID;
            OP_UNIQUE_ID: id_byte = uid[7:0];
            OP_STD_ID: begin
                if (idx == 3'h0) begin
                    id_byte = MAKER_ID;
                end else if (idx == 3'h1) begin
                    id_byte = MEMORY_TYPE_BYTE;
                end else begin
                    id_byte = CAPACITY_BYTE;
                end
            end
            default: id_byte = IDLE_BYTE;
        endcase
    endfunction

    function automatic logic [5:0] addr_len(input logic [7:0] op);
        case (op)
            OP_MAKER_DEV_ID_DUAL: addr_len = ADDR_MODE_BITS;
            OP_UNIQUE_ID: addr_len = UID_DUMMY_BITS;
            default: addr_len = ADDR_BITS;
        endcase
    endfunction

    function automatic logic blk_protected(input logic tb, input logic [2:0] bp, input logic [2:0] idx);
        logic [3:0] n;
        if (bp == 3'h0) begin
            n = 4'h0;
        end else if (bp >= BP_ALL) begin
            n = NUM_BLOCKS;
        end else begin
            n = 4'h1 << (bp - 3'h1);
        end
        blk_protected = tb ? ({1'b0, idx} < n) : ({1'b0, idx} >= NUM_BLOCKS - n);
    endfunction

    // ****************************************
    // serial protocol
    // ****************************************
    always_comb begin
        phase_next = phase_reg;
        op_next = op_reg;
        rx_next = rx_reg;
        cnt_next = cnt_reg;
        tx_next = tx_reg;
        txcnt_next = txcnt_reg;
        byte_next = byte_reg;
        dual_next = dual_reg;
        swap_next = swap_reg;
        dout_next = dout_reg;
        oe_next = oe_reg;
        exec_block = 1'b0;
        exec_chip = 1'b0;
        exec_sleep = 1'b0;
        exec_wake_plain = 1'b0;
        exec_wake_id = 1'b0;
        in_byte = {rx_reg[6:0], pins.io0};
        rx_shift = dual_reg ? {rx_reg[29:0], pins.io1, pins.io0} : {rx_reg[30:0], pins.io0};
        cnt_inc = cnt_reg + (dual_reg ? 6'h2 : 6'h1);
        wstep = dual_reg ? 4'h2 : 4'h1;
        byte_inc = (op_reg == OP_STD_ID && byte_reg == STD_ID_LAST) ? 3'h0 : byte_reg + 3'h1;
        if (pins.cs_rise) begin
            phase_next = PH_CMD;
            op_next = 8'h00;
            cnt_next = 6'h00;
            dual_next = 1'b0;
            oe_next = 1'b0;
            // erase and sleep commit only when select rose exactly on a byte boundary; ABh with dummy or output bits wakes at any bit
            if (phase_reg == PH_END) begin
                case (op_reg)
                    OP_BLOCK_ERASE: exec_block = 1'b1;
                    OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: exec_chip = 1'b1;
                    OP_POWER_DOWN: exec_sleep = 1'b1;
                    default: ;
                endcase
            end else if (op_reg == OP_RELEASE_ID && phase_reg == PH_ADDR && cnt_reg == 6'h00) begin
                exec_wake_plain = 1'b1;
            end else if (op_reg == OP_RELEASE_ID && (phase_reg == PH_ADDR || phase_reg == PH_OUT)) begin
                exec_wake_id = 1'b1;
            end
        end else if (!pins.cs_n && pins.sclk_rise) begin
            case (phase_reg)
                PH_CMD: begin
                    rx_next = {rx_reg[30:0], pins.io0};
                    cnt_next = cnt_reg + 6'h1;
                    if (cnt_reg == CMD_BITS - 6'h1) begin
                        op_next = in_byte;
                        cnt_next = 6'h00;
                        phase_next = PH_SKIP;
                        if (pwr_reg != PWR_NORMAL) begin
                            if (in_byte == OP_RELEASE_ID) begin
                                phase_next = PH_ADDR;
                            end
                        end else if (busy_reg) begin
                            // ABh, erase and all else but 05h dropped mid-cycle
                            if (in_byte == OP_READ_STATUS) begin
                                phase_next = PH_OUT;
                            end
                        end else begin
                            case (in_byte)
                                OP_BLOCK_ERASE, OP_MAKER_DEV_ID, OP_RELEASE_ID, OP_UNIQUE_ID: begin
                                    phase_next = PH_ADDR;
                                end
                                OP_MAKER_DEV_ID_DUAL: begin
                                    phase_next = PH_ADDR;
                                    dual_next = 1'b1;
                                end
                                OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_POWER_DOWN: phase_next = PH_END;
                                OP_STD_ID, OP_READ_STATUS: phase_next = PH_OUT;
                                default: phase_next = PH_SKIP;
                            endcase
                        end
                        byte_next = 3'h0;
                        txcnt_next = BYTE_BITS;
                        tx_next = id_byte(in_byte, 3'h0, 1'b0, stat_byte);
                    end
                end
                PH_ADDR: begin
                    rx_next = rx_shift;
                    cnt_next = cnt_inc;
                    if (cnt_inc == addr_len(op_reg)) begin
                        // low address bit picks which identity byte leads
                        swap_next = (op_reg == OP_MAKER_DEV_ID_DUAL) ? rx_shift[8] : rx_shift[0];
                        byte_next = 3'h0;
                        txcnt_next = BYTE_BITS;
                        tx_next = id_byte(op_reg, 3'h0, swap_next, stat_byte);
                        phase_next = (op_reg == OP_BLOCK_ERASE) ? PH_END : PH_OUT;
                    end
                end
                // any clock past the last byte cancels the pending action
                PH_END: phase_next = PH_SKIP;
                default: ;
            endcase
        end else if (!pins.cs_n && pins.sclk_fall && phase_reg == PH_OUT) begin
            // msb first; dual puts the upper bit on io1
            dout_next = tx_reg[7:6];
            oe_next = 1'b1;
            tx_next = dual_reg ? {tx_reg[5:0], 2'h0} : {tx_reg[6:0], 1'b0};
            txcnt_next = txcnt_reg - wstep;
            if (txcnt_reg == wstep) begin
                // stream repeats until select rises
                byte_next = byte_inc;
                txcnt_next = BYTE_BITS;
                tx_next = id_byte(op_reg, byte_inc, swap_reg, stat_byte);
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            phase_reg <= PH_CMD;
            op_reg <= 8'h00;
            rx_reg <= 32'h0000_0000;
            cnt_reg <= 6'h00;
            tx_reg <= 8'h00;
            txcnt_reg <= 4'h0;
            byte_reg <= 3'h0;
            dual_reg <= 1'b0;
            swap_reg <= 1'b0;
            dout_reg <= 2'h0;
            oe_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            op_reg <= op_next;
            rx_reg <= rx_next;
            cnt_reg <= cnt_next;
            tx_reg <= tx_next;
            txcnt_reg <= txcnt_next;
            byte_reg <= byte_next;
            dual_reg <= dual_next;
            swap_reg <= swap_next;
            dout_reg <= dout_next;
            oe_reg <= oe_next;
        end
    end

    // ****************************************
    // erase cycle and power state
    // ****************************************
    always_comb begin
        busy_next = busy_reg;
        wel_next = wel_reg;
        ers_cnt_next = ers_cnt_reg;
        start_next = 1'b0;
        all_next = all_reg;
        eaddr_next = eaddr_reg;
        pwr_next = pwr_reg;
        pwr_cnt_next = pwr_cnt_reg;
        if (busy_reg) begin
            if (ers_cnt_reg == 32'h0000_0000) begin
                busy_next = 1'b0;
                wel_next = 1'b0;
            end else begin
                ers_cnt_next = ers_cnt_reg - 32'h0000_0001;
            end
        end else if (exec_block && wel_reg) begin
            if (!blk_protected(protect_top_bottom_select_i, block_protect_i,
                               rx_reg[BLOCK_LSB+2:BLOCK_LSB])) begin
                busy_next = 1'b1;
                start_next = 1'b1;
                all_next = 1'b0;
                eaddr_next = {rx_reg[23:BLOCK_LSB], BLOCK_OFFSET_ZERO};
                ers_cnt_next = 32'(BLOCK_ERASE_CYC - 1);
            end
        end else if (exec_chip && wel_reg && block_protect_i == 3'h0) begin
            busy_next = 1'b1;
            start_next = 1'b1;
            all_next = 1'b1;
            eaddr_next = 24'h00_0000;
            ers_cnt_next = 32'(ARRAY_ERASE_CYC - 1);
        end
        // a latch set in the same cycle as the clear wins
        if (wel_set_i) begin
            wel_next = 1'b1;
        end
        case (pwr_reg)
            PWR_NORMAL: begin
                if (exec_sleep) begin
                    pwr_next = PWR_ENTER;
                    pwr_cnt_next = SLEEP_ENTRY_CYCLES - 16'h1;
                end
            end
            PWR_SLEEP: begin
                if (exec_wake_plain) begin
                    pwr_next = PWR_WAKE;
                    pwr_cnt_next = WAKE_PLAIN_CYCLES - 16'h1;
                end else if (exec_wake_id) begin
                    pwr_next = PWR_WAKE;
                    pwr_cnt_next = WAKE_ID_CYCLES - 16'h1;
                end
            end
            PWR_ENTER, PWR_WAKE: begin
                if (pwr_cnt_reg == 16'h0000) begin
                    pwr_next = (pwr_reg == PWR_ENTER) ? PWR_SLEEP : PWR_NORMAL;
                end else begin
                    pwr_cnt_next = pwr_cnt_reg - 16'h1;
                end
            end
            default: pwr_next = PWR_NORMAL;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            busy_reg <= 1'b0;
            wel_reg <= 1'b0;
            ers_cnt_reg <= 32'h0000_0000;
            start_reg <= 1'b0;
            all_reg <= 1'b0;
            eaddr_reg <= 24'h00_0000;
            pwr_reg <= PWR_NORMAL;
            pwr_cnt_reg <= 16'h0000;
        end else begin
            busy_reg <= busy_next;
            wel_reg <= wel_next;
            ers_cnt_reg <= ers_cnt_next;
            start_reg <= start_next;
            all_reg <= all_next;
            eaddr_reg <= eaddr_next;
            pwr_reg <= pwr_next;
            pwr_cnt_reg <= pwr_cnt_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign io1_o = dout_reg[1];
    assign io0_o = dout_reg[0];
    assign io1_oe_o = oe_reg;
    assign io0_oe_o = oe_reg & dual_reg;
    assign write_enable_latch_o = wel_reg;
    assign busy_o = busy_reg;
    assign deep_sleep_o = (pwr_reg == PWR_SLEEP);
    assign erase_start_o = start_reg;
    assign erase_all_o = all_reg;
    assign erase_addr_o = eaddr_reg;

endmodule
`default_nettype wire

// file: test/flash_cmd_core_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_core_monitor
    import flash_cmd_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // watched ports
    input wire logic wel_set_i,
    input wire logic [2:0] block_protect_i,
    input wire logic io1_oe_o,
    input wire logic write_enable_latch_o,
    input wire logic busy_o,
    input wire logic deep_sleep_o,
    input wire logic erase_start_o,
    input wire logic erase_all_o,
    input wire logic [23:0] erase_addr_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    start_pulse_a: assert property (erase_start_o |=> !erase_start_o) else $error("start not a pulse");
    busy_rise_a: assert property ($rose(busy_o) |-> erase_start_o) else $error("busy without start");
    start_gate_a: assert property (erase_start_o |-> write_enable_latch_o && !deep_sleep_o)
        else $error("erase started while not allowed");
    busy_hold_a: assert property (erase_start_o |-> busy_o [*8]) else $error("busy dropped early");
    end_latch_a: assert property ($fell(busy_o) |-> !write_enable_latch_o || $past(wel_set_i))
        else $error("latch kept after erase");
    chip_prot_a: assert property (erase_start_o && erase_all_o |-> block_protect_i == 3'h0 && erase_addr_o == 24'h000000)
        else $error("chip erase while protected");
    block_base_a: assert property (erase_start_o && !erase_all_o |-> erase_addr_o[15:0] == BLOCK_OFFSET_ZERO)
        else $error("block address not aligned");
    reset_idle_a: assert property ($fell(sys_rst_i) |-> !busy_o && !deep_sleep_o && !write_enable_latch_o)
        else $error("not idle after reset");
    sleep_quiet_a: assert property (deep_sleep_o |-> !io1_oe_o && !busy_o) else $error("activity while asleep");
    cover property (erase_start_o && erase_all_o);
    cover property (erase_start_o && !erase_all_o);
    cover property ($rose(deep_sleep_o));
endmodule
`default_nettype wire

// file: test/spi_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
    // clock
    input wire logic sys_clk_i,
    // pins
    input wire logic miso_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic mosi_o,
    output logic io1_o
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end
    // released line toggles so a stale bit never looks valid
    always @(posedge sys_clk_i) begin
        if (cs_n_o) begin
            mosi_o <= ~mosi_o;
        end
    end
    assign io1_o = mosi_o;
    // mode 0 frame, six sys clocks per sclk phase; ntx bits out then nrx bits in
    task automatic frame(input logic [63:0] tx, input int ntx, input int nrx, output logic [63:0] rx);
        rx = '0;
        @(posedge sys_clk_i) cs_n_o <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        for (int i = 0; i < ntx + nrx; i++) begin
            mosi_o <= (i < ntx) ? tx[63 - i] : 1'b0;
            repeat (6) @(posedge sys_clk_i);
            sclk_o <= 1'b1;
            repeat (6) @(posedge sys_clk_i);
            if (i >= ntx) rx = {rx[62:0], miso_i};
            sclk_o <= 1'b0;
        end
        repeat (6) @(posedge sys_clk_i);
        cs_n_o <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
    endtask
endmodule
`default_nettype wire

// file: test/serial_flash_erase_power_id_cmds_tb.sv
`timescale 1ns/10ps
`default_nettype none
module serial_flash_erase_power_id_cmds_tb;
    import flash_cmd_pkg::*;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cs_n, sclk, mosi, hio1, io0_o, io0_oe_o, io1_o, io1_oe_o, latch, busy, sleep, start, all;
    logic wel_set = 1'b0;
    logic tb_sel = 1'b0;
    logic [2:0] bp = 3'h0;
    logic [23:0] eaddr, a;
    logic [63:0] rx;
    int err_total = 0;
    int tests_run = 0;
    wire logic io1_w = io1_oe_o ? io1_o : hio1;
    always #5 sys_clk_i = ~sys_clk_i;
    spi_host_model host(.sys_clk_i, .miso_i(io1_w), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi), .io1_o(hio1));
    flash_cmd_core #(.BLOCK_ERASE_CYC(20), .ARRAY_ERASE_CYC(400)) dut(.sys_clk_i, .sys_rst_i, .cs_n_i(cs_n),
        .sclk_i(sclk), .io0_i(io0_oe_o ? io0_o : mosi), .io1_i(io1_w), .io0_o, .io0_oe_o, .io1_o, .io1_oe_o,
        .wel_set_i(wel_set), .protect_top_bottom_select_i(tb_sel), .block_protect_i(bp),
        .write_enable_latch_o(latch), .busy_o(busy), .deep_sleep_o(sleep), .erase_start_o(start),
        .erase_all_o(all), .erase_addr_o(eaddr));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    function automatic logic [3:0] odd4(input logic [7:0] v); return {v[7], v[5], v[3], v[1]}; endfunction
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // set the latch, send the frame, then see whether a cycle ran
    task automatic erase(input logic [63:0] tx, input int n, input logic go, input logic [23:0] ea);
        logic seen;
        seen = 1'b0;
        @(posedge sys_clk_i) wel_set <= 1'b1;
        @(posedge sys_clk_i) wel_set <= 1'b0;
        host.frame(tx, n, 0, rx);
        repeat (10) @(posedge sys_clk_i) seen |= busy;
        if (go) check({all, eaddr}, {n == 8, ea});
        repeat (500) @(posedge sys_clk_i);
        check({seen, busy, latch}, {go, 1'b0, !go});
    endtask
    initial begin
        void'($urandom(32'h0F9B));
        repeat (5) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        check({latch, busy, sleep}, 3'h0);
        host.frame({OP_STD_ID, 56'h0}, 8, 24, rx);
        check(rx[23:0], {MAKER_ID, MEMORY_TYPE_BYTE, CAPACITY_BYTE});
        for (int s = 0; s < 2; s++) begin
            host.frame({OP_MAKER_DEV_ID, 23'h0, s[0], 32'h0}, 32, 32, rx);
            check(rx[31:0], s ? {2{DEVICE_ID, MAKER_ID}} : {2{MAKER_ID, DEVICE_ID}});
        end
        host.frame({OP_RELEASE_ID, 56'h0}, 32, 16, rx);
        check(rx[15:0], {DEVICE_ID, DEVICE_ID});
        host.frame({OP_UNIQUE_ID, 56'h0}, 40, 64, rx);
        check(rx, UNIQUE_SERIAL);
        host.frame({OP_MAKER_DEV_ID_DUAL, 12'h000, 4'hF, 40'h0}, 24, 8, rx);
        check(rx[7:0], {odd4(MAKER_ID), odd4(DEVICE_ID)});
        $display("id reads done");
        for (int k = 0; k < 4; k++) begin
            a = 24'($urandom);
            tb_sel <= 1'($urandom);
            erase({OP_BLOCK_ERASE, a, 32'h0}, 32, 1'b1, {a[23:16], 16'h0000});
        end
        erase({OP_BLOCK_ERASE, a, 32'h0}, 33, 1'b0, 24'h000000);
        bp <= BP_ALL;
        erase({OP_BLOCK_ERASE, a, 32'h0}, 32, 1'b0, 24'h000000);
        bp <= 3'h1;
        erase({OP_CHIP_ERASE_A, 56'h0}, 8, 1'b0, 24'h000000);
        bp <= 3'h0;
        erase({OP_CHIP_ERASE_B, 56'h0}, 8, 1'b1, 24'h000000);
        erase({OP_CHIP_ERASE_A, 56'h0}, 8, 1'b1, 24'h000000);
        @(posedge sys_clk_i) wel_set <= 1'b1;
        @(posedge sys_clk_i) wel_set <= 1'b0;
        host.frame({OP_CHIP_ERASE_A, 56'h0}, 8, 0, rx);
        host.frame({OP_RELEASE_ID, 56'h0}, 8, 0, rx);
        check({busy, sleep}, 2'h2);
        repeat (500) @(posedge sys_clk_i);
        $display("erase done");
        host.frame({OP_POWER_DOWN, 56'h0}, 8, 0, rx);
        repeat (SLEEP_ENTRY_CYCLES + 20) @(posedge sys_clk_i);
        check(sleep, 1'b1);
        erase({OP_CHIP_ERASE_B, 56'h0}, 8, 1'b0, 24'h000000);
        check(sleep, 1'b1);
        host.frame({OP_RELEASE_ID, 56'h0}, 8, 0, rx);
        check(sleep, 1'b0);
        repeat (WAKE_PLAIN_CYCLES + 20) @(posedge sys_clk_i);
        host.frame({OP_STD_ID, 56'h0}, 8, 24, rx);
        check(rx[23:0], {MAKER_ID, MEMORY_TYPE_BYTE, CAPACITY_BYTE});
        $display("sleep done");
        results();
    end
    // about seven times the expected run length
    initial begin
        #1000000;
        err_total++;
        results();
    end
endmodule
bind flash_cmd_core flash_cmd_core_monitor mon(.sys_clk_i, .sys_rst_i, .wel_set_i, .block_protect_i, .io1_oe_o,
    .write_enable_latch_o, .busy_o, .deep_sleep_o, .erase_start_o, .erase_all_o, .erase_addr_o);
`default_nettype wire
